// *** tes_map.vh ***
/*
  Constants for the terminal error status block: error register field
  positions, reset values, error type codes and the transmit error limit.
  Assumes inclusion by bare name from the design files of this block.
*/
// Overview of operation
// - String error bit 15 sets at once with any error bit except mode bits.
// - String error clears at wordstring end, or before next word after no-ack.
// - Other error bits stay latched after the string error bit clears.
// - Every interrupt vector carries the current string error bit as its MSB.
// - Bit 14 sets after seven consecutive transmit errors; holds until power cycle.
// - Shutdown flag also drives a transmit-disable lamp output.
// - Bit 13 sets when the monitor detects a transmit error; only bit 14 inhibits sending.
// - Transmit error output sets a sticky lamp flip-flop and queues an error message.
// - Bits 12 to 10 hold the binary monitor error type; zero means none.
// - Code 1 when more wordstrings arrive than the message string count allows.
// - Code 2 for a transmitted data word with bad coding, parity or sync.
// - Code 3 when the transmitter keeps sending after the string should end.
// - Code 4 when the bus goes quiet after a data sync pattern.
// - Code 5 for a transmitted label with bad coding, parity or sync.
// - Code 6 when label extension differs from channel id or string count all ones.
// - Code 7 when the monitor expects data but sees a quiet bus.
// - Read command returns the whole 16-bit error register.
// - Bits 2 and 1 show operating mode: normal, near test, or test.
`ifndef TES_MAP_VH
`define TES_MAP_VH

// ***************************************************************
// Error register layout
// ***************************************************************
`define TES_BIT_STRING     15
`define TES_BIT_SHUTDOWN   14
`define TES_BIT_TXERR      13
`define TES_CODE_HI        12
`define TES_CODE_LO        10
`define TES_BIT_PAM_TI     9
`define TES_BIT_NOACK_RD   7
`define TES_BIT_NOACK_WR   6
`define TES_BIT_SHORT      3
`define TES_MODE_HI        2
`define TES_MODE_LO        1
`define TES_ERR_RESET      16'h0000
// Bits 9..3 that enter latched from other detectors
`define TES_MISC_MASK      16'h03f8
// Fields that raise the string error bit (everything but mode and bit 0)
`define TES_STRING_MASK    16'h7ff8

// ***************************************************************
// Monitor error types
// ***************************************************************
`define TES_CODE_NONE      3'h0
`define TES_CODE_EOM       3'h1
`define TES_CODE_DATA      3'h2
`define TES_CODE_EOS       3'h3
`define TES_CODE_QSYNC     3'h4
`define TES_CODE_LABEL     3'h5
`define TES_CODE_NOTOK     3'h6
`define TES_CODE_NOWORD    3'h7

// ***************************************************************
// Operating mode and limits
// ***************************************************************
`define TES_MODE_NORMAL    2'h0
`define TES_MODE_NEAR      2'h1
`define TES_MODE_TEST      2'h3
`define TES_TXERR_LIMIT    3'h7
`define TES_MSC_ALL_ONES   5'h1f

`endif

// *** tes_encode.v ***
/*
  Monitor error type encoder: turns the transmit monitor's individual
  detections into the three-bit error type, one type per event.
  Assumes the detection inputs are single-cycle pulses from the monitor.
*/
`timescale 1ns/1ns
`include "tes_map.vh"

module tes_encode (
  input  wire       label_bad,
  input  wire [3:0] label_extension,
  input  wire [3:0] channel_identifier,
  input  wire [4:0] message_string_count,
  input  wire       label_seen,
  input  wire       data_bad,
  input  wire       quiet_after_sync,
  input  wire       no_next_word,
  input  wire       extra_data,
  input  wire       extra_string,
  output reg  [2:0] code
);

  wire not_ok;

  // Extension check only counts on a label just sent by this terminal
  assign not_ok = label_seen &&
                  ((label_extension != channel_identifier) ||
                   (message_string_count == `TES_MSC_ALL_ONES));

  // Priority puts label faults first since they void the whole string
  always @* begin
    if (label_bad) begin
      code = `TES_CODE_LABEL;
    end else if (not_ok) begin
      code = `TES_CODE_NOTOK;
    end else if (data_bad) begin
      code = `TES_CODE_DATA;
    end else if (quiet_after_sync) begin
      code = `TES_CODE_QSYNC;
    end else if (no_next_word) begin
      code = `TES_CODE_NOWORD;
    end else if (extra_data) begin
      code = `TES_CODE_EOS;
    end else if (extra_string) begin
      code = `TES_CODE_EOM;
    end else begin
      code = `TES_CODE_NONE;
    end
  end

endmodule

// *** tes_top.v ***
/*
  Terminal error status: holds the 16-bit error register, the string error
  flag, the transmit error and shutdown flags, the error lamps and the
  interrupt vector with the string error bit on top.
  Assumes all inputs are synchronous to CLK and event inputs are one-cycle
  pulses; SYS_RST stands for a power cycle.
*/
`timescale 1ns/1ns
`include "tes_map.vh"

module tes_top (
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        MON_LABEL_BAD,
  input  wire        MON_LABEL_SEEN,
  input  wire [3:0]  LABEL_EXTENSION,
  input  wire [3:0]  CHANNEL_IDENTIFIER,
  input  wire [4:0]  MESSAGE_STRING_COUNT,
  input  wire        MON_DATA_BAD,
  input  wire        MON_QUIET_AFTER_SYNC,
  input  wire        MON_NO_NEXT_WORD,
  input  wire        MON_EXTRA_DATA,
  input  wire        MON_EXTRA_STRING,
  input  wire [6:0]  OTHER_ERR,
  input  wire [3:0]  TEST_PIN_FAULT,
  input  wire        TX_STRING,
  input  wire        STRING_DONE,
  input  wire        WORD_START,
  input  wire [14:0] VECTOR_IN,
  input  wire        VECTOR_LOAD,
  input  wire        READ_ERROR_REGISTER_COMMAND,
  input  wire        LAMP_CLEAR,
  output reg  [15:0] READ_DATA,
  output reg         READ_VALID,
  output reg  [15:0] INTERRUPT_VECTOR,
  output reg         TRANSMIT_ERROR_FLAG,
  output reg         TRANSMITTER_SHUTDOWN_FLAG,
  output reg         TX_ENABLE,
  output reg         TX_ERROR_LAMP,
  output reg         TX_DISABLE_LAMP,
  output reg         COM_ERROR_MSG
);

  // ***************************************************************
  // Functions
  // ***************************************************************

  // Mode from the number of failed test pins; two or more means test mode
  function [1:0] mode_of;
    input [3:0] pins;
    reg   [2:0] n;
    begin
      n = {2'h0, pins[0]} + {2'h0, pins[1]} + {2'h0, pins[2]} + {2'h0, pins[3]};
      if (n == 3'h0) begin
        mode_of = `TES_MODE_NORMAL;
      end else if (n == 3'h1) begin
        mode_of = `TES_MODE_NEAR;
      end else begin
        mode_of = `TES_MODE_TEST;
      end
    end
  endfunction

  // ***************************************************************
  // State
  // ***************************************************************

  reg  [15:0] err_reg;
  reg  [2:0]  tx_err_count;
  reg         string_err;
  reg         noack_pending;
  reg         tx_err_in_string;
  reg  [14:0] vector_hold;

  reg  [15:0] next_err;
  reg  [2:0]  next_count;
  reg         next_string;
  reg         next_noack;
  reg         next_in_string;
  reg         next_shutdown;

  wire [2:0]  mon_code;
  wire        mon_event;
  wire        noack_event;
  wire        misc_event;
  wire [15:0] misc_bits;
  wire        any_event;

  // ***************************************************************
  // Monitor error type
  // ***************************************************************

  tes_encode u_encode (
    .label_bad            (MON_LABEL_BAD),
    .label_extension      (LABEL_EXTENSION),
    .channel_identifier   (CHANNEL_IDENTIFIER),
    .message_string_count (MESSAGE_STRING_COUNT),
    .label_seen           (MON_LABEL_SEEN),
    .data_bad             (MON_DATA_BAD),
    .quiet_after_sync     (MON_QUIET_AFTER_SYNC),
    .no_next_word         (MON_NO_NEXT_WORD),
    .extra_data           (MON_EXTRA_DATA),
    .extra_string         (MON_EXTRA_STRING),
    .code                 (mon_code)
  );

  // Event groups; a shut-down transmitter cannot raise monitor errors
  assign mon_event   = (mon_code != `TES_CODE_NONE) && !err_reg[`TES_BIT_SHUTDOWN];
  assign misc_bits   = {6'h00, OTHER_ERR, 3'h0} & `TES_MISC_MASK;
  assign misc_event  = |misc_bits;
  assign noack_event = OTHER_ERR[`TES_BIT_NOACK_RD - 3] | OTHER_ERR[`TES_BIT_NOACK_WR - 3];
  assign any_event   = mon_event | misc_event;

  // ***************************************************************
  // Next-state logic for the error register and counters
  // ***************************************************************

  // Errors of a new string replace the stale ones; within a string they add
  always @* begin
    next_err       = err_reg;
    next_count     = tx_err_count;
    next_string    = string_err;
    next_noack     = noack_pending;
    next_in_string = tx_err_in_string;
    next_shutdown  = err_reg[`TES_BIT_SHUTDOWN];

    // Closing a string lets stale bits stay visible under a clear flag
    if (STRING_DONE) begin
      next_string    = 1'b0;
      next_in_string = 1'b0;
      if (TX_STRING && !tx_err_in_string && !mon_event) begin
        next_count = 3'h0;
      end
    end
    // After a missing bus acknowledge the flag drops before the next word
    if (WORD_START && noack_pending) begin
      next_string = 1'b0;
      next_noack  = 1'b0;
    end

    if (any_event) begin
      if (!string_err) begin
        next_err[`TES_BIT_TXERR]                = 1'b0;
        next_err[`TES_CODE_HI:`TES_CODE_LO]     = `TES_CODE_NONE;
        next_err[`TES_BIT_PAM_TI:`TES_BIT_SHORT] = 7'h00;
      end
      next_err = next_err | misc_bits;
      // Missing read acknowledge also flags a transmit error, no count
      if (OTHER_ERR[`TES_BIT_NOACK_RD - 3]) begin
        next_err[`TES_BIT_TXERR] = 1'b1;
      end
      if (noack_event) begin
        next_noack = 1'b1;
      end
      if (mon_event) begin
        next_err[`TES_BIT_TXERR]            = 1'b1;
        next_err[`TES_CODE_HI:`TES_CODE_LO] = mon_code;
        next_in_string                      = 1'b1;
        // Count saturates at the limit; only an unbroken run reaches it
        if (tx_err_count != `TES_TXERR_LIMIT) begin
          next_count = tx_err_count + 3'h1;
        end
        if (tx_err_count == `TES_TXERR_LIMIT - 3'h1) begin
          next_shutdown = 1'b1;
        end
      end
      // Event in the closing cycle wins over the clear
      next_string = 1'b1;
    end

    next_err[`TES_BIT_SHUTDOWN]           = next_shutdown;
    next_err[`TES_MODE_HI:`TES_MODE_LO]   = mode_of(TEST_PIN_FAULT);
    next_err[0]                           = 1'b0;
    next_err[`TES_BIT_STRING]             = next_string;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************

  // Error register, counters and string tracking
  always @(posedge CLK) begin
    if (SYS_RST) begin
      err_reg          <= `TES_ERR_RESET;
      tx_err_count     <= 3'h0;
      string_err       <= 1'b0;
      noack_pending    <= 1'b0;
      tx_err_in_string <= 1'b0;
    end else begin
      err_reg          <= next_err;
      tx_err_count     <= next_count;
      string_err       <= next_string;
      noack_pending    <= next_noack;
      tx_err_in_string <= next_in_string;
    end
  end

  // Flag pins follow the register; shutdown is never released but by reset
  always @(posedge CLK) begin
    if (SYS_RST) begin
      TRANSMIT_ERROR_FLAG       <= 1'b0;
      TRANSMITTER_SHUTDOWN_FLAG <= 1'b0;
      TX_ENABLE                 <= 1'b1;
      TX_DISABLE_LAMP           <= 1'b0;
    end else begin
      TRANSMIT_ERROR_FLAG       <= next_err[`TES_BIT_TXERR];
      TRANSMITTER_SHUTDOWN_FLAG <= next_err[`TES_BIT_SHUTDOWN];
      TX_ENABLE                 <= !next_err[`TES_BIT_SHUTDOWN];
      TX_DISABLE_LAMP           <= next_err[`TES_BIT_SHUTDOWN];
    end
  end

  // Sticky lamp; a rising transmit error queues one message, set beats clear
  always @(posedge CLK) begin
    if (SYS_RST) begin
      TX_ERROR_LAMP <= 1'b0;
      COM_ERROR_MSG <= 1'b0;
    end else begin
      COM_ERROR_MSG <= next_err[`TES_BIT_TXERR] && !TRANSMIT_ERROR_FLAG;
      if (next_err[`TES_BIT_TXERR] && !TRANSMIT_ERROR_FLAG) begin
        TX_ERROR_LAMP <= 1'b1;
      end else if (LAMP_CLEAR) begin
        TX_ERROR_LAMP <= 1'b0;
      end
    end
  end

  // Vector keeps its low bits; the top bit tracks the string flag each cycle
  always @(posedge CLK) begin
    if (SYS_RST) begin
      vector_hold      <= 15'h0000;
      INTERRUPT_VECTOR <= 16'h0000;
    end else begin
      if (VECTOR_LOAD) begin
        vector_hold <= VECTOR_IN;
      end
      INTERRUPT_VECTOR <= {next_string, (VECTOR_LOAD ? VECTOR_IN : vector_hold)};
    end
  end

  // Read command answers one cycle later with the register as it stood
  always @(posedge CLK) begin
    if (SYS_RST) begin
      READ_DATA  <= 16'h0000;
      READ_VALID <= 1'b0;
    end else begin
      READ_VALID <= READ_ERROR_REGISTER_COMMAND;
      if (READ_ERROR_REGISTER_COMMAND) begin
        READ_DATA <= err_reg;
      end
    end
  end

endmodule

// *** tes_assertions.sv ***
/*
  Checker for the terminal error status block: timing relations between its pins.
  Assumes it is bound to tes_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module tes_checker (
  input wire        CLK,
  input wire        SYS_RST,
  input wire        MON_DATA_BAD,
  input wire [14:0] VECTOR_IN,
  input wire        VECTOR_LOAD,
  input wire        READ_ERROR_REGISTER_COMMAND,
  input wire        READ_VALID,
  input wire [15:0] READ_DATA,
  input wire [15:0] INTERRUPT_VECTOR,
  input wire        TRANSMIT_ERROR_FLAG,
  input wire        TRANSMITTER_SHUTDOWN_FLAG,
  input wire        TX_ENABLE,
  input wire        TX_ERROR_LAMP,
  input wire        TX_DISABLE_LAMP,
  input wire        COM_ERROR_MSG
);
  // ************
  // Pin relations
  // ************
  // One domain, so clock and reset are given once for all
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_read_answer;
    READ_ERROR_REGISTER_COMMAND |=> READ_VALID;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_quiet;
    !READ_ERROR_REGISTER_COMMAND |=> !READ_VALID;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("valid without read");
  property p_event_flags;
    MON_DATA_BAD && !TRANSMITTER_SHUTDOWN_FLAG |=> TRANSMIT_ERROR_FLAG && INTERRUPT_VECTOR[15];
  endproperty
  a_event_flags: assert property (p_event_flags) else $error("event flags missing");
  property p_event_read;
    MON_DATA_BAD && !TRANSMITTER_SHUTDOWN_FLAG ##1 READ_ERROR_REGISTER_COMMAND |=> READ_DATA[15] && READ_DATA[13];
  endproperty
  a_event_read: assert property (p_event_read) else $error("error bits not read");
  property p_shutdown_hold;
    TRANSMITTER_SHUTDOWN_FLAG |-> !TX_ENABLE ##1 TRANSMITTER_SHUTDOWN_FLAG;
  endproperty
  a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown not held");
  property p_disable_lamp;
    TX_DISABLE_LAMP == TRANSMITTER_SHUTDOWN_FLAG;
  endproperty
  a_disable_lamp: assert property (p_disable_lamp) else $error("disable lamp wrong");
  property p_error_lamp;
    $rose(TRANSMIT_ERROR_FLAG) |-> TX_ERROR_LAMP && COM_ERROR_MSG;
  endproperty
  a_error_lamp: assert property (p_error_lamp) else $error("lamp or message missing");
  property p_msg_pulse;
    COM_ERROR_MSG |=> !COM_ERROR_MSG;
  endproperty
  a_msg_pulse: assert property (p_msg_pulse) else $error("message not a pulse");
  property p_vector_low;
    VECTOR_LOAD |=> INTERRUPT_VECTOR[14:0] == $past(VECTOR_IN);
  endproperty
  a_vector_low: assert property (p_vector_low) else $error("vector not loaded");
endmodule

bind tes_top tes_checker i_checker (
  .CLK(CLK), .SYS_RST(SYS_RST), .MON_DATA_BAD(MON_DATA_BAD), .VECTOR_IN(VECTOR_IN), .VECTOR_LOAD(VECTOR_LOAD),
  .READ_ERROR_REGISTER_COMMAND(READ_ERROR_REGISTER_COMMAND), .READ_VALID(READ_VALID), .READ_DATA(READ_DATA),
  .INTERRUPT_VECTOR(INTERRUPT_VECTOR), .TRANSMIT_ERROR_FLAG(TRANSMIT_ERROR_FLAG),
  .TRANSMITTER_SHUTDOWN_FLAG(TRANSMITTER_SHUTDOWN_FLAG), .TX_ENABLE(TX_ENABLE),
  .TX_ERROR_LAMP(TX_ERROR_LAMP), .TX_DISABLE_LAMP(TX_DISABLE_LAMP), .COM_ERROR_MSG(COM_ERROR_MSG)
);

// *** tes_host.sv ***
/*
  Host subsystem model: issues the error register read and takes the answer.
  Assumes its task is called just after a rising clock edge.
*/
`timescale 1ns/1ns
module tes_host (
  input  wire        clk,
  input  wire [15:0] read_data,
  input  wire        read_valid,
  output reg         read_error_register_command
);
  initial read_error_register_command = 1'b0;
  // One-cycle command, then a bounded wait for the valid pulse
  task read_reg(output [15:0] value, output ok);
    integer n;
    begin
      read_error_register_command = 1'b1;
      @(posedge clk);
      #1;
      read_error_register_command = 1'b0;
      n = 0;
      while (read_valid !== 1'b1 && n < 8) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      ok = (read_valid === 1'b1);
      value = read_data;
    end
  endtask
endmodule

// *** test_terminal_error_status.sv ***
/*
  Testbench for the terminal error status block: monitor events, string
  clearing, shutdown and register reads. Assumes the host model and checker.
*/
`timescale 1ns/1ns
module test_terminal_error_status;
  reg         clk, sys_rst, tx_string;
  reg  [6:0]  mon_pulse, other_err;
  reg  [3:0]  ctl, label_extension, channel_identifier, test_pin_fault;
  reg  [4:0]  message_string_count;
  reg  [14:0] vector_in;
  reg  [15:0] got;
  reg         ok;
  wire        read_cmd, read_valid, tx_err_flag, shutdown, tx_enable, err_lamp, dis_lamp, com_msg;
  wire [15:0] read_data, ivec;
  integer     n_fail, num_checks, k;
  localparam [3:0] pulse_done = 4'h8;
  localparam [3:0] pulse_word = 4'h4;
  localparam [3:0] pulse_vec  = 4'h2;
  localparam [3:0] pulse_lamp = 4'h1;

  tes_top i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .MON_LABEL_BAD(mon_pulse[2]), .MON_LABEL_SEEN(mon_pulse[1]),
    .LABEL_EXTENSION(label_extension), .CHANNEL_IDENTIFIER(channel_identifier),
    .MESSAGE_STRING_COUNT(message_string_count), .MON_DATA_BAD(mon_pulse[5]),
    .MON_QUIET_AFTER_SYNC(mon_pulse[3]), .MON_NO_NEXT_WORD(mon_pulse[0]), .MON_EXTRA_DATA(mon_pulse[4]),
    .MON_EXTRA_STRING(mon_pulse[6]), .OTHER_ERR(other_err), .TEST_PIN_FAULT(test_pin_fault),
    .TX_STRING(tx_string), .STRING_DONE(ctl[3]), .WORD_START(ctl[2]), .VECTOR_IN(vector_in),
    .VECTOR_LOAD(ctl[1]), .READ_ERROR_REGISTER_COMMAND(read_cmd), .LAMP_CLEAR(ctl[0]),
    .READ_DATA(read_data), .READ_VALID(read_valid), .INTERRUPT_VECTOR(ivec),
    .TRANSMIT_ERROR_FLAG(tx_err_flag), .TRANSMITTER_SHUTDOWN_FLAG(shutdown), .TX_ENABLE(tx_enable),
    .TX_ERROR_LAMP(err_lamp), .TX_DISABLE_LAMP(dis_lamp), .COM_ERROR_MSG(com_msg)
  );
  tes_host i_host (.clk(clk), .read_data(read_data), .read_valid(read_valid), .read_error_register_command(read_cmd));

  // ************
  // Clock, tasks
  // ************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Inputs move 1 ns after the edge so no race with the design's sampling
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task read_expect(input [15:0] exp);
    begin
      i_host.read_reg(got, ok);
      check({15'h0000, ok}, 16'h0001);
      check(got, exp);
    end
  endtask
  // Codes 1..7 map onto mon_pulse bits 6..0
  task mon(input [2:0] code);
    begin
      mon_pulse = 7'h40 >> (code - 3'h1);
      tick;
      mon_pulse = 7'h00;
    end
  endtask
  task pulse(input [3:0] which);
    begin
      ctl = which;
      tick;
      ctl = 4'h0;
    end
  endtask
  // Reset stands for a power cycle, so it may be repeated mid-run
  task do_reset;
    begin
      sys_rst = 1'b1;
      repeat (6) tick;
      sys_rst = 1'b0;
      tick;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  // ************
  // Tests
  // ************
  initial begin
    n_fail = 0;
    num_checks = 0;
    {sys_rst, mon_pulse, other_err, ctl, vector_in} = 0;
    tx_string = 1'b1;
    label_extension = 4'h3;
    channel_identifier = 4'h5;
    message_string_count = 5'h04;
    test_pin_fault = 4'h1;
    do_reset;
    read_expect(16'h0002);
    $display("test reset done");
    // Each code, then string end, then a clean string to zero the run count
    for (k = 1; k < 8; k = k + 1) begin
      mon(k[2:0]);
      check({13'h0000, ivec[15], tx_err_flag, err_lamp}, 16'h0007);
      check({15'h0000, com_msg}, {15'h0000, k == 1});
      read_expect({3'h5, k[2:0], 10'h002});
      pulse(pulse_done);
      read_expect({3'h1, k[2:0], 10'h002});
      pulse(pulse_done);
    end
    label_extension = 4'h5;
    mon(3'h6);
    read_expect(16'h3c02);
    message_string_count = 5'h1f;
    mon(3'h6);
    read_expect(16'hb802);
    pulse(pulse_done);
    pulse(pulse_done);
    $display("test codes done");
    other_err = 7'h10;
    tick;
    other_err = 7'h00;
    read_expect(16'ha082);
    pulse(pulse_word);
    read_expect(16'h2082);
    // A short-string error with the load raises the vector's top bit
    other_err = 7'h01;
    vector_in = 15'h1234;
    pulse(pulse_vec);
    other_err = 7'h00;
    check(ivec, 16'h9234);
    pulse(pulse_done);
    check(ivec, 16'h1234);
    read_expect(16'h000a);
    pulse(pulse_lamp);
    check({15'h0000, err_lamp}, 16'h0000);
    $display("test other errors done");
    for (k = 0; k < 12; k = k + 1) begin
      mon(3'h2);
      pulse(pulse_done);
      if (k == 5) pulse(pulse_done);
    end
    check({15'h0000, shutdown}, 16'h0000);
    mon(3'h2);
    check({13'h0000, shutdown, dis_lamp, tx_enable}, 16'h0006);
    pulse(pulse_done);
    mon(3'h5);
    read_expect(16'h6802);
    do_reset;
    check({14'h0000, shutdown, tx_enable}, 16'h0001);
    read_expect(16'h0002);
    // Two failed test pins mean test mode
    test_pin_fault = 4'h3;
    tick;
    read_expect(16'h0006);
    $display("test shutdown done");
    conclude;
  end
  // Whole run is about a hundred cycles; this limit is far beyond it
  initial begin
    #100000;
    n_fail = n_fail + 1;
    conclude;
  end
endmodule
